// ---- design/pbs_regs.vh ----
// register offsets, field positions, reset values and timing counts for the bypass slot
`ifndef PBS_REGS_VH
`define PBS_REGS_VH

// register indices; byte address is four times the index
`define PBS_IDX_CTL 8'h22
`define PBS_IDX_IRQ_STAT 8'h24
`define PBS_IDX_IRQ_MASK 8'h25
`define PBS_IDX_IRQ_SRC 8'h26
`define PBS_IDX_PIN_CFG 8'h27

// control register fields
`define PBS_CTL_EN_BIT 7
`define PBS_CTL_SIG_DETECT_IRQ_ENABLE_BIT 6
`define PBS_CTL_FB_BIT 1
`define PBS_CTL_SD_BIT 0
`define PBS_CTL_UNUSED_VAL 4'h0

// control register reset values
`define PBS_RST_EN 1'b0
`define PBS_RST_SIG_DETECT_IRQ_ENABLE 1'b0
`define PBS_RST_FB 1'b1

// interrupt status and mask fields
`define PBS_IRQ_SD_BIT 0
`define PBS_IRQ_FBCLR_BIT 1
`define PBS_IRQ_W 2

// pin configuration fields, used only while the slot is disabled
`define PBS_CFG_OE5_BIT 0
`define PBS_CFG_OE4_BIT 1
`define PBS_CFG_D5_BIT 2
`define PBS_CFG_D4_BIT 3
`define PBS_CFG_W 4

// pins power up as inputs pulled high
`define PBS_PIN_RST_LEVEL 1'b1

// loss-of-signal to output latency bound
`define PBS_CLK_MHZ 50
`define PBS_LOS_MAX_NS 400
`define PBS_LOS_MAX_CYC ((`PBS_LOS_MAX_NS * `PBS_CLK_MHZ) / 1000)

`endif

// ---- design/pbs_pin_filter.v ----
// pin synchroniser with agreement filter for one input pin
`timescale 1ns/100ps
module pbs_pin_filter #(
    parameter RST_LEVEL = 1'b1
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // raw pin level
    input wire pin_i,
    // filtered level
    output reg level_q
);
    reg sync1_q; // first stage, only the second stage reads it
    reg sync2_q; // second stage
    reg sync3_q; // third stage

    // three-stage chain; level moves only when stages two and three agree
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= RST_LEVEL;
            sync2_q <= RST_LEVEL;
            sync3_q <= RST_LEVEL;
            level_q <= RST_LEVEL;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q) begin
                level_q <= sync3_q;
            end
        end
    end
endmodule

// ---- design/pbs_slot.v ----
// port bypass slot: ahb-lite registers, pin takeover, signal-detect interrupt
`timescale 1ns/100ps
`include "pbs_regs.vh"

// Notes on behaviour
// R01: enable turns two pins into bypass/detect
// R02: enable overrides pin config except bypass select
// R03: disabled slot ignores other control bits
// R04: enabled detect transitions assert active-low interrupt
// R05: interrupt loads source register with 22h
// R06: no interrupt while detect interrupt disabled; bypass clear events still raise irq when mask bit 1 is set
// R07: bypass bit set keeps circuit normal
// R08: bypass bit clear drives circuit into bypass
// R09: low filtered detect clears bypass bit quickly
// R10: read values come through synchroniser and filter
// R11: enabled detect bit is read-only pin mirror
// R12: detect bit one means signal present
// R13: pins power up as pulled-up inputs
// R14: software reads default, then writes with enable
// R15: software changes bypass only while detect high
// R16: unused bits ignore writes, read constant
module pbs_slot #(
    parameter ADDR_W = 8
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [ADDR_W-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // bypass select override from the bit control logic
    input wire bsel_active,
    input wire bsel_value,
    // force-bypass pin
    input wire port3_pin5_i,
    output reg port3_pin5_o,
    output reg port3_pin5_oe,
    // signal-detect pin
    input wire port3_pin4_i,
    output reg port3_pin4_o,
    output reg port3_pin4_oe,
    // interrupts
    output reg irq,
    output reg int_n,
    output reg [7:0] bypass_irq_source
);
    // byte addresses of the registers; index times four, kept at full width
    // so that shifting the 8-bit index never drops a bit
    localparam [9:0] A_CTL = {`PBS_IDX_CTL, 2'b00};
    localparam [9:0] A_STAT = {`PBS_IDX_IRQ_STAT, 2'b00};
    localparam [9:0] A_MASK = {`PBS_IDX_IRQ_MASK, 2'b00};
    localparam [9:0] A_SRC = {`PBS_IDX_IRQ_SRC, 2'b00};
    localparam [9:0] A_CFG = {`PBS_IDX_PIN_CFG, 2'b00};
    // one-hot register selects
    localparam [4:0] S_CTL = 5'h01;
    localparam [4:0] S_STAT = 5'h02;
    localparam [4:0] S_MASK = 5'h04;
    localparam [4:0] S_SRC = 5'h08;
    localparam [4:0] S_CFG = 5'h10;

    // address decode shared by read and write paths; unmapped gives zero
    function [4:0] pbs_decode;
        input [ADDR_W-1:0] a;
        begin
            // address bits above the low byte are not decoded
            case ({2'b00, a[7:0]})
                A_CTL: pbs_decode = S_CTL;
                A_STAT: pbs_decode = S_STAT;
                A_MASK: pbs_decode = S_MASK;
                A_SRC: pbs_decode = S_SRC;
                A_CFG: pbs_decode = S_CFG;
                default: pbs_decode = 5'h00;
            endcase
        end
    endfunction

    // filtered pin levels
    // both pins pass the same three-stage filter, so a pin change is seen
    // four clocks late at the earliest; a glitch of a single clock never
    // reaches the control logic
    wire [1:0] pin_raw; // bit 0 detect pin, bit 1 bypass pin
    wire [1:0] pin_filt; // synchronised and filtered copies
    assign pin_raw = {port3_pin5_i, port3_pin4_i};

    // one filter per pin; the detect pin and the bypass pin readback both pass one
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
            pbs_pin_filter #(
                .RST_LEVEL(`PBS_PIN_RST_LEVEL)
            ) u_filt (
                .hclk(hclk),
                .hresetn(hresetn),
                .pin_i(pin_raw[gi]),
                .level_q(pin_filt[gi])
            );
        end
    endgenerate

    wire sd_filt; // filtered detect level, one means signal present
    wire fb_pin_filt; // filtered level seen on the bypass pin
    assign sd_filt = pin_filt[0]; // R12
    assign fb_pin_filt = pin_filt[1];

    // control and status state
    // these bits keep their values with the slot off; software can stage
    // the interrupt enable and bypass level before the takeover
    reg en_q; // slot takeover enable
    reg sig_detect_irq_enable_q; // detect interrupt enable
    reg fb_q; // force bypass control
    reg [`PBS_IRQ_W-1:0] stat_q; // sticky events
    reg [`PBS_IRQ_W-1:0] mask_q; // interrupt mask
    reg [`PBS_CFG_W-1:0] cfg_q; // plain pin config when slot disabled
    reg sd_prev_q; // last filtered detect level for edge finding

    // ahb data phase tracking
    // only one access is ever outstanding, so one select register suffices
    reg wr_pend_q; // write data phase in progress
    reg rd_pend_q; // read wait cycle in progress
    reg [4:0] dsel_q; // register selected by the pending access

    // address phase qualification
    // a read wait state holds hreadyout low, so no new address phase
    // can be taken while a read is being answered
    wire addr_ok; // valid transfer offered to this slave
    wire wr_fire; // write data present this cycle
    assign addr_ok = hsel & hready & htrans[1];
    assign wr_fire = wr_pend_q;

    // write strobes per register
    // strobes are live only in the data phase of a write, while hwdata
    // stands on the bus
    wire wr_ctl;
    wire wr_stat;
    wire wr_mask;
    wire wr_src;
    wire wr_cfg;
    assign wr_ctl = wr_fire & dsel_q[0];
    assign wr_stat = wr_fire & dsel_q[1];
    assign wr_mask = wr_fire & dsel_q[2];
    assign wr_src = wr_fire & dsel_q[3];
    assign wr_cfg = wr_fire & dsel_q[4];

    // events
    wire sd_edge; // filtered transition while taken over with the detect interrupt enabled
    wire fb_hw_clr; // hardware clear condition on the bypass bit
    wire fb_clr_evt; // bypass bit actually knocked down
    wire en_next; // enable as it will be after this cycle
    // en_next lets the write that sets the enable also see a missing signal,
    // so a slot switched on without a signal drops into bypass at once
    // instead of showing one clock of normal mode
    assign en_next = wr_ctl ? hwdata[`PBS_CTL_EN_BIT] : en_q;
    assign sd_edge = en_q & sig_detect_irq_enable_q & (sd_filt != sd_prev_q); // R04 R06
    assign fb_hw_clr = en_next & ~sd_filt; // R09
    assign fb_clr_evt = fb_hw_clr & (fb_q | (wr_ctl & hwdata[`PBS_CTL_FB_BIT]));

    // readback of the control register
    // with the slot off the bypass bit reads the pin itself, which is how
    // software learns a strap set by an external pull-down before enabling
    wire [7:0] ctl_rd; // bypass bit: enabled, own bit; disabled, pin level via filter; detect bit always the filtered pin
    assign ctl_rd = {en_q, sig_detect_irq_enable_q, `PBS_CTL_UNUSED_VAL, // R16
                     en_q ? fb_q : fb_pin_filt, // R10
                     sd_filt}; // R11

    // read mux
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (dsel_q)
            S_CTL: rd_mux = {24'h00_0000, ctl_rd};
            S_STAT: rd_mux = {{(32-`PBS_IRQ_W){1'b0}}, stat_q};
            S_MASK: rd_mux = {{(32-`PBS_IRQ_W){1'b0}}, mask_q};
            S_SRC: rd_mux = {24'h00_0000, bypass_irq_source};
            S_CFG: rd_mux = {{(32-`PBS_CFG_W){1'b0}}, cfg_q};
            default: rd_mux = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    // bus front end: writes take no wait, reads take one so data is fresh
    // the wait lets a read straight after a write see the new value, at the
    // cost of one clock per read; hresp never leaves okay because every
    // address answers, unmapped ones with zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            dsel_q <= 5'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0; // always okay
            wr_pend_q <= 1'b0;
            if (rd_pend_q) begin
                // wait cycle over: sample state after any prior write
                hrdata <= rd_mux;
                hreadyout <= 1'b1;
                rd_pend_q <= 1'b0;
            end else if (addr_ok) begin
                // hsize ignored; only whole words are expected
                dsel_q <= pbs_decode(haddr);
                if (hwrite) begin
                    wr_pend_q <= 1'b1;
                end else begin
                    rd_pend_q <= 1'b1;
                    hreadyout <= 1'b0;
                end
            end
        end
    end

    // control register; disabled slot keeps bits but they steer nothing
    // a software set of the bypass bit while the signal is gone would only
    // pulse the pin into normal mode, so the hardware clear wins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q <= `PBS_RST_EN;
            sig_detect_irq_enable_q <= `PBS_RST_SIG_DETECT_IRQ_ENABLE;
            fb_q <= `PBS_RST_FB;
        end else begin
            if (wr_ctl) begin
                en_q <= hwdata[`PBS_CTL_EN_BIT];
                sig_detect_irq_enable_q <= hwdata[`PBS_CTL_SIG_DETECT_IRQ_ENABLE_BIT];
            end
            // hardware clear beats a software set
            if (fb_hw_clr) begin
                fb_q <= 1'b0; // R09
            end else if (wr_ctl) begin
                fb_q <= hwdata[`PBS_CTL_FB_BIT];
            end
        end
    end

    // edge tracker runs always so enabling does not fake a transition
    // it resets to the pull-up level the filters come up with, so the
    // release of reset shows no edge either
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sd_prev_q <= `PBS_PIN_RST_LEVEL;
        end else begin
            sd_prev_q <= sd_filt;
        end
    end

    // sticky status, write one to clear; a new event wins over the clear
    // status bit one records each hardware knock-down of the bypass bit,
    // which software cannot otherwise tell from its own write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= {`PBS_IRQ_W{1'b0}};
        end else begin
            if (wr_stat) begin
                stat_q <= stat_q & ~hwdata[`PBS_IRQ_W-1:0];
            end
            if (sd_edge) begin
                stat_q[`PBS_IRQ_SD_BIT] <= 1'b1; // R04
            end
            if (fb_clr_evt) begin
                stat_q[`PBS_IRQ_FBCLR_BIT] <= 1'b1;
            end
        end
    end

    // source register: any write clears it, a new detect event wins
    // it holds the register index of this slot, so one read tells
    // software which slot raised the interrupt
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bypass_irq_source <= 8'h00;
        end else if (sd_edge) begin
            bypass_irq_source <= `PBS_IDX_CTL; // R05
        end else if (wr_src) begin
            bypass_irq_source <= 8'h00;
        end
    end

    // mask and plain pin config
    // the pin config reaches the pins only with the slot off; it lets the
    // two pins serve as plain outputs when no bypass circuit is fitted
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= {`PBS_IRQ_W{1'b0}};
            cfg_q <= {`PBS_CFG_W{1'b0}}; // R13
        end else begin
            if (wr_mask) begin
                mask_q <= hwdata[`PBS_IRQ_W-1:0];
            end
            if (wr_cfg) begin
                cfg_q <= hwdata[`PBS_CFG_W-1:0];
            end
        end
    end

    // interrupt outputs, registered
    // one clock behind the status; both polarities come from flops so
    // neither output can glitch while the status is cleared
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
            int_n <= 1'b1;
        end else begin
            irq <= |(stat_q & mask_q);
            int_n <= ~|(stat_q & mask_q); // R04
        end
    end

    // pin drivers; after reset both pins float as inputs for the pull-ups
    // oe high means the slot drives the pin; the pull-ups set the level
    // seen while it floats
    // the bypass select path is honoured only while the slot is taken over
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port3_pin5_o <= 1'b0;
            port3_pin5_oe <= 1'b0; // R13
            port3_pin4_o <= 1'b0;
            port3_pin4_oe <= 1'b0;
        end else if (en_q) begin
            // takeover: push-pull bypass output, detect pin input
            port3_pin5_oe <= 1'b1; // R01 R02
            port3_pin4_oe <= 1'b0; // R01
            port3_pin4_o <= 1'b0;
            if (bsel_active) begin
                port3_pin5_o <= bsel_value; // R02
            end else begin
                // high keeps normal mode, low forces bypass; a software clear
                // lands on the pin one cycle after fb_q drops, a hardware clear at the same edge
                port3_pin5_o <= fb_q & ~fb_hw_clr; // R07 R08 R09
            end
        end else begin
            // slot off: control bits have no say over the pins
            port3_pin5_oe <= cfg_q[`PBS_CFG_OE5_BIT]; // R03
            port3_pin5_o <= cfg_q[`PBS_CFG_D5_BIT];
            port3_pin4_oe <= cfg_q[`PBS_CFG_OE4_BIT];
            port3_pin4_o <= cfg_q[`PBS_CFG_D4_BIT];
        end
    end
endmodule

// ---- test/pbs_slot_assertions.sv ----
// port-level checker for the bypass slot
`timescale 1ns/100ps
module pbs_slot_checker (
    // clock, reset and bus
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // pins and interrupts
    input wire bsel_active,
    input wire bsel_value,
    input wire port3_pin4_i,
    input wire port3_pin5_o,
    input wire port3_pin5_oe,
    input wire port3_pin4_oe,
    input wire irq,
    input wire int_n,
    input wire [7:0] bypass_irq_source
);
    reg [4:0] lo_q; // cycles with detect pin low, saturating
    wire tk = hsel && hready && htrans[1]; // transfer taken
    // low time counter; a plain delay would miss re-triggers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            lo_q <= 5'h00;
        else if (port3_pin4_i)
            lo_q <= 5'h00;
        else if (lo_q != 5'h1f)
            lo_q <= lo_q + 5'h01;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_write_no_wait: assert property (tk && hwrite |=> hreadyout)
        else $error("write phase stalled");
    a_read_one_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    a_resp_okay: assert property (!hresp)
        else $error("error response");
    a_irq_pins: assert property (int_n == !irq)
        else $error("interrupt outputs disagree");
    a_source_value: assert property (bypass_irq_source == 8'h00 || bypass_irq_source == 8'h22)
        else $error("bad source value");
    a_loss_bypass: assert property (lo_q >= 5'h14 && port3_pin5_oe && !port3_pin4_oe
        && !bsel_active && !$past(bsel_active) |-> !port3_pin5_o)
        else $error("bypass late after loss");
    a_bsel_wins: assert property (bsel_active && $past(bsel_active) && $stable(bsel_value)
        && port3_pin5_oe && !port3_pin4_oe |-> port3_pin5_o == bsel_value)
        else $error("bypass select ignored");
endmodule
bind pbs_slot pbs_slot_checker pbs_slot_checker_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bsel_active(bsel_active), .bsel_value(bsel_value),
    .port3_pin4_i(port3_pin4_i), .port3_pin5_o(port3_pin5_o), .port3_pin5_oe(port3_pin5_oe),
    .port3_pin4_oe(port3_pin4_oe), .irq(irq), .int_n(int_n),
    .bypass_irq_source(bypass_irq_source));

// ---- test/pbs_bypass_model.sv ----
// behavioural external bypass circuit with its signal detector
`timescale 1ns/100ps
module pbs_bypass_model (
    // force line from the slot, low selects bypass
    input wire force_line,
    // bench command: remove the high-speed signal
    input wire loss,
    // detector output and loop mode
    output wire sd_line,
    output wire bypassed
);
    // detector high while a signal is present
    assign sd_line = !loss;
    // low force line puts the loop in bypass
    assign bypassed = !force_line;
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the bypass slot
`timescale 1ns/100ps
`include "pbs_regs.vh"
module testbench;
    localparam [7:0] CTL = `PBS_IDX_CTL * 4;
    localparam [7:0] STAT = `PBS_IDX_IRQ_STAT * 4;
    localparam [7:0] MASK = `PBS_IDX_IRQ_MASK * 4;
    localparam [7:0] SRC = `PBS_IDX_IRQ_SRC * 4;
    localparam [7:0] CFG = `PBS_IDX_PIN_CFG * 4;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg [7:0] haddr = 8'h00;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg bsel_active = 1'b0;
    reg bsel_value = 1'b0;
    reg loss = 1'b0; // partner command
    reg [31:0] r; // last read data
    wire [31:0] hrdata;
    wire [7:0] src;
    wire hreadyout, hresp, p5o, p5oe, p4o, p4oe, irq, int_n, sd_line, bypassed;
    // pin levels: weak pull-up on pin5, detector drives pin4
    wire p5 = p5oe ? p5o : 1'b1;
    wire p4 = p4oe ? p4o : sd_line;
    integer fails = 0;
    integer check_count = 0;
    integer cyc = 0;
    pbs_slot pbs_slot_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bsel_active(bsel_active),
        .bsel_value(bsel_value), .port3_pin5_i(p5), .port3_pin5_o(p5o), .port3_pin5_oe(p5oe),
        .port3_pin4_i(p4), .port3_pin4_o(p4o), .port3_pin4_oe(p4oe), .irq(irq),
        .int_n(int_n), .bypass_irq_source(src));
    pbs_bypass_model pbs_bypass_model_inst (.force_line(p5), .loss(loss), .sd_line(sd_line),
        .bypassed(bypassed));
    // 50 MHz clock
    initial begin
        forever #10 hclk = ~hclk;
    end
    // hang guard, far above the expected run
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails = fails + 1;
            summarize;
        end
    end
    task summarize;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        check_count = check_count + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task idle(input integer n);
        repeat (n) @(posedge hclk);
    endtask
    // single ahb-lite transfer; waits on hready, result lands in r
    task xfer(input [7:0] a, input w, input [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    // reset values, pins as inputs, unmapped place
    task t_reset;
        xfer(CTL, 1'b0, 32'h0);
        chk(r, 32'h03);
        chk({30'h0, p5oe, p4oe}, 32'h0);
        xfer(8'h00, 1'b1, 32'hff);
        xfer(8'h00, 1'b0, 32'h0);
        chk(r, 32'h0);
    endtask
    // takeover, read-only bits, manual bypass
    task t_enable;
        xfer(CTL, 1'b1, 32'hc2);
        idle(2);
        chk({27'h0, hresp, p4o, p5oe, p4oe, p5o}, 32'h5);
        xfer(CTL, 1'b1, 32'hff);
        xfer(CTL, 1'b0, 32'h0);
        chk(r, 32'hc3);
        xfer(CTL, 1'b1, 32'hc0);
        idle(2);
        chk({31'h0, bypassed}, 32'h1);
        xfer(CTL, 1'b1, 32'hc2);
    endtask
    // loss of signal: auto bypass, masked then unmasked interrupt
    task t_loss;
        xfer(MASK, 1'b1, 32'h0);
        loss <= 1'b1;
        idle(20);
        chk({29'h0, irq, p5o, bypassed}, 32'h1);
        xfer(STAT, 1'b0, 32'h0);
        chk(r, 32'h3);
        xfer(SRC, 1'b0, 32'h0);
        chk(r, 32'h22);
        chk({24'h0, src}, 32'h22);
        xfer(CTL, 1'b0, 32'h0);
        chk(r, 32'hc0);
        xfer(MASK, 1'b1, 32'h3);
        idle(2);
        chk({30'h0, irq, int_n}, 32'h2);
        loss <= 1'b0;
        idle(20);
        xfer(STAT, 1'b1, 32'h3);
        idle(2);
        chk({30'h0, irq, int_n}, 32'h1);
        xfer(SRC, 1'b1, 32'h0);
        xfer(CTL, 1'b1, 32'hc2);
    endtask
    // detect interrupt disabled: edges leave no event
    task t_quiet;
        xfer(CTL, 1'b1, 32'h82);
        xfer(MASK, 1'b1, 32'h1);
        loss <= 1'b1;
        idle(20);
        loss <= 1'b0;
        idle(20);
        xfer(STAT, 1'b0, 32'h0);
        chk({31'h0, r[0]}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        xfer(SRC, 1'b0, 32'h0);
        chk(r, 32'h0);
        xfer(CTL, 1'b1, 32'h82);
    endtask
    // bypass select overrides the force bit
    task t_bsel;
        bsel_active <= 1'b1;
        idle(3);
        chk({31'h0, p5o}, 32'h0);
        bsel_value <= 1'b1;
        idle(3);
        chk({31'h0, p5o}, 32'h1);
        bsel_active <= 1'b0;
    endtask
    // disabled slot releases pins; reads come from filtered pins
    task t_off;
        xfer(CTL, 1'b1, 32'h00);
        idle(2);
        chk({30'h0, p5oe, p4oe}, 32'h0);
        xfer(CTL, 1'b0, 32'h0);
        chk(r, 32'h03);
        xfer(CFG, 1'b1, 32'h1);
        xfer(CTL, 1'b1, 32'h42);
        idle(6);
        chk({28'h0, p5oe, p4oe, p5o, p4o}, 32'h8);
        xfer(CTL, 1'b0, 32'h0);
        chk(r, 32'h41);
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        idle(6);
        t_reset;
        t_enable;
        t_loss;
        t_quiet;
        t_bsel;
        t_off;
        summarize;
    end
endmodule
